// ===== pkg/srap_pkg.sv
// shared constants, types and register map of the serial register access port
package srap_pkg;
  // frame layout
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int HEAD_BITS = 16;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int NUM_SLOTS = 44;

  // control fields inside the device's own registers
  localparam int SLOT_CFGA = 0;
  localparam int SLOT_USR = 6;
  localparam int CFGA_ASC_HI = 5;
  localparam int CFGA_ASC_LO = 2;
  localparam int USR_HOLD_BIT = 0;

  // host command registers, byte addresses on apb
  localparam int HOST_AW = 8;
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_ADDR = 8'h04;
  localparam logic [7:0] HOST_WDATA = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0C;
  localparam logic [7:0] HOST_RDATA = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_KEEP = 2;
  localparam int CTRL_STOP = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_HOLD = 2;

  // how a register slot gets its content
  typedef enum logic [2:0] {KIND_RW, KIND_FUSE, KIND_CLASS, KIND_PART,
    KIND_MAKER_LO, KIND_MAKER_HI, KIND_CAL, KIND_SYNC} srap_kind_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rst;
    srap_kind_t kind;
  } srap_slot_t;

  // one entry per byte; wide registers sit low byte first
  localparam srap_slot_t SLOT_MAP [NUM_SLOTS] = '{
    '{15'h000, 8'h30, KIND_RW}, '{15'h002, 8'h00, KIND_RW},
    '{15'h003, 8'h00, KIND_CLASS}, '{15'h004, 8'h00, KIND_PART},
    '{15'h00C, 8'h00, KIND_MAKER_LO}, '{15'h00D, 8'h00, KIND_MAKER_HI},
    '{15'h010, 8'h00, KIND_RW}, '{15'h029, 8'h00, KIND_RW},
    '{15'h02A, 8'h00, KIND_RW}, '{15'h02B, 8'h11, KIND_RW},
    '{15'h02C, 8'h00, KIND_SYNC}, '{15'h030, 8'h00, KIND_RW},
    '{15'h031, 8'hA0, KIND_RW}, '{15'h032, 8'h00, KIND_RW},
    '{15'h033, 8'hA0, KIND_RW}, '{15'h038, 8'h00, KIND_RW},
    '{15'h03B, 8'h00, KIND_RW}, '{15'h048, 8'h00, KIND_RW},
    '{15'h060, 8'h01, KIND_RW}, '{15'h061, 8'h01, KIND_RW},
    '{15'h062, 8'h01, KIND_RW}, '{15'h064, 8'h02, KIND_RW},
    '{15'h068, 8'h61, KIND_RW}, '{15'h06A, 8'h00, KIND_CAL},
    '{15'h06B, 8'h00, KIND_RW}, '{15'h06C, 8'h01, KIND_RW},
    '{15'h06E, 8'h88, KIND_RW}, '{15'h070, 8'h00, KIND_RW},
    '{15'h071, 8'h00, KIND_RW}, '{15'h07A, 8'h00, KIND_FUSE},
    '{15'h07B, 8'h00, KIND_FUSE}, '{15'h07C, 8'h00, KIND_FUSE},
    '{15'h07E, 8'h00, KIND_FUSE}, '{15'h07F, 8'h00, KIND_FUSE},
    '{15'h09D, 8'h00, KIND_FUSE}, '{15'h102, 8'h00, KIND_FUSE},
    '{15'h103, 8'h00, KIND_FUSE}, '{15'h112, 8'h00, KIND_FUSE},
    '{15'h113, 8'h00, KIND_FUSE}, '{15'h142, 8'h00, KIND_FUSE},
    '{15'h152, 8'h00, KIND_FUSE}, '{15'h160, 8'h00, KIND_RW},
    '{15'h200, 8'h01, KIND_RW}, '{15'h201, 8'h02, KIND_RW}
  };
endpackage

// ===== pkg/srap_link_if.sv
// serial link between host controller and register access port
interface srap_link_if;
  logic sclk;
  logic serialSelectN;
  logic serialIn;
  logic serialOutDrive;
  logic serialOutEn;
  logic serialOut;

  // released line idles high, as with a pull-up
  assign serialOut = serialOutEn ? serialOutDrive : 1'b1;

  modport device (
    input sclk, serialSelectN, serialIn,
    output serialOutDrive, serialOutEn
  );
  modport host (
    output sclk, serialSelectN, serialIn,
    input serialOut
  );
endinterface

// ===== rtl/srap_sync.sv
// two flip-flop synchroniser for asynchronous pins
module srap_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins in, synchronised copy out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } srap_sync_t;

  srap_sync_t state_reg;
  srap_sync_t state_next;

  // the first stage feeds only the second
  always_comb
  begin
    state_next.first = asyncIn;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= {RESET_VAL, RESET_VAL};
    else
      state_reg <= state_next;
  end

  assign syncOut = state_reg.second;
endmodule

// ===== rtl/srap_device_end.sv
// register access port: serial slave end with the configuration bank
//
// The APB slave port was left to the implementer.
module srap_device_end #(
  parameter logic [7:0] PART_CLASS = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h21, // arbitrary value
  parameter logic [15:0] MAKER_ID = 16'h1234 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial link
  srap_link_if.device link,
  // fuse storage and live status from the converter
  input wire logic [srap_pkg::NUM_SLOTS*8-1:0] fuseTrim,
  input wire logic [7:0] calStatus,
  input wire logic [7:0] syncPosition,
  // register contents for the converter
  output logic [srap_pkg::NUM_SLOTS*8-1:0] regImage
);
  ////////////////////////////////////////
  // state

  typedef struct packed {
    logic [srap_pkg::NUM_SLOTS-1:0][7:0] bank;
    logic fuseDone;
    logic sclkPrev;
    logic [srap_pkg::CNT_W-1:0] bitCnt;
    logic isRead;
    logic [srap_pkg::ADDR_W-1:0] addr;
    logic [srap_pkg::HEAD_BITS-1:0] shiftIn;
    logic [7:0] txByte;
    logic outData;
    logic outEn;
  } srap_dev_t;

  srap_dev_t cur;
  srap_dev_t nxt;
  logic [2:0] pinSync;
  logic sclkS;
  logic selNS;
  logic sdiS;

  ////////////////////////////////////////
  // pin synchronisers

  // select resets high so no frame is seen at power up
  srap_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h2)
  ) pinSyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({link.sclk, link.serialSelectN, link.serialIn}),
    .syncOut(pinSync)
  );

  assign sclkS = pinSync[2];
  assign selNS = pinSync[1];
  assign sdiS = pinSync[0];

  ////////////////////////////////////////
  // helpers

  // read one byte; unmapped offsets answer zero
  function automatic logic [7:0] readSlot(
    input logic [srap_pkg::NUM_SLOTS-1:0][7:0] bank,
    input logic [srap_pkg::ADDR_W-1:0] a
  );
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < srap_pkg::NUM_SLOTS; i++)
    begin
      if (srap_pkg::SLOT_MAP[i].addr == a)
      begin
        case (srap_pkg::SLOT_MAP[i].kind)
          srap_pkg::KIND_CLASS: v = PART_CLASS;
          srap_pkg::KIND_PART: v = PART_ID;
          srap_pkg::KIND_MAKER_LO: v = MAKER_ID[7:0];
          srap_pkg::KIND_MAKER_HI: v = MAKER_ID[15:8];
          srap_pkg::KIND_CAL: v = calStatus;
          srap_pkg::KIND_SYNC: v = syncPosition;
          default: v = bank[i];
        endcase
      end
    end
    return v;
  endfunction

  // streaming address step, wraps inside the address field
  function automatic logic [srap_pkg::ADDR_W-1:0] stepAddr(
    input logic [srap_pkg::ADDR_W-1:0] a,
    input logic ascend,
    input logic hold
  );
    logic [srap_pkg::ADDR_W-1:0] r;
    r = a;
    if (!hold)
    begin
      if (ascend)
        r = a + 15'h0001;
      else
        r = a - 15'h0001;
    end
    return r;
  endfunction

  ////////////////////////////////////////
  // frame engine and register bank

  // every step is event driven from sclk edges, so a stopped clock
  // just parks the frame; nothing counts idle time
  always_comb
  begin
    logic [srap_pkg::HEAD_BITS-1:0] newShift;
    logic [srap_pkg::ADDR_W-1:0] stepped;
    logic rise;
    logic fall;
    logic ascend;
    logic hold;
    newShift = {cur.shiftIn[srap_pkg::HEAD_BITS-2:0], sdiS};
    stepped = cur.addr;
    rise = sclkS & ~cur.sclkPrev;
    fall = ~sclkS & cur.sclkPrev;
    ascend = cur.bank[srap_pkg::SLOT_CFGA][srap_pkg::CFGA_ASC_HI]
      | cur.bank[srap_pkg::SLOT_CFGA][srap_pkg::CFGA_ASC_LO];
    hold = cur.bank[srap_pkg::SLOT_USR][srap_pkg::USR_HOLD_BIT];
    nxt = cur;
    nxt.sclkPrev = sclkS;

    // trim values come from fuses once, right after reset release
    if (!cur.fuseDone)
    begin
      nxt.fuseDone = 1'b1;
      for (int i = 0; i < srap_pkg::NUM_SLOTS; i++)
      begin
        if (srap_pkg::SLOT_MAP[i].kind == srap_pkg::KIND_FUSE)
          nxt.bank[i] = fuseTrim[i*8 +: 8];
      end
    end

    if (selNS)
    begin
      // idle or aborted frame: partial byte is simply dropped
      nxt.bitCnt = '0;
      nxt.isRead = 1'b0;
      nxt.outEn = 1'b0;
      nxt.outData = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        nxt.shiftIn = newShift;
        nxt.bitCnt = cur.bitCnt + 5'h01;
        if (cur.bitCnt == 5'(srap_pkg::HEAD_BITS - 1))
        begin
          // header complete: direction then address
          nxt.isRead = newShift[srap_pkg::HEAD_BITS-1];
          nxt.addr = newShift[srap_pkg::ADDR_W-1:0];
          nxt.txByte = readSlot(cur.bank, newShift[srap_pkg::ADDR_W-1:0]);
        end
        else if (cur.bitCnt == 5'(srap_pkg::FRAME_BITS - 1))
        begin
          if (!cur.isRead)
          begin
            for (int i = 0; i < srap_pkg::NUM_SLOTS; i++)
            begin
              if (srap_pkg::SLOT_MAP[i].addr == cur.addr
                && (srap_pkg::SLOT_MAP[i].kind == srap_pkg::KIND_RW
                || srap_pkg::SLOT_MAP[i].kind == srap_pkg::KIND_FUSE))
                nxt.bank[i] = newShift[7:0];
            end
          end
          // next byte of a stream follows on the same header
          stepped = stepAddr(cur.addr, ascend, hold);
          nxt.addr = stepped;
          nxt.bitCnt = 5'(srap_pkg::HEAD_BITS);
          nxt.txByte = readSlot(nxt.bank, stepped);
        end
      end
      // data changes after the falling edge, ready for the next rise
      if (fall && cur.isRead && cur.bitCnt >= 5'(srap_pkg::HEAD_BITS))
      begin
        nxt.outData = cur.txByte[7];
        nxt.txByte = {cur.txByte[6:0], 1'b0};
        nxt.outEn = 1'b1;
      end
    end
  end

  ////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      for (int i = 0; i < srap_pkg::NUM_SLOTS; i++)
        cur.bank[i] <= srap_pkg::SLOT_MAP[i].rst;
      cur.sclkPrev <= 1'b0;
    end
    else
      cur <= nxt;
  end

  ////////////////////////////////////////
  // outputs

  assign link.serialOutDrive = cur.outData;
  assign link.serialOutEn = cur.outEn;
  assign regImage = cur.bank;
endmodule

// ===== rtl/srap_host_end.sv
// host controller end: apb command registers driving the serial link
module srap_host_end #(
  parameter int SCLK_HALF = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srap_pkg::HOST_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  srap_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_END} srap_hst_t;

  typedef struct packed {
    srap_hst_t st;
    logic [15:0] div;
    logic [srap_pkg::CNT_W-1:0] left;
    logic [srap_pkg::FRAME_BITS-1:0] tx;
    logic [7:0] rx;
    logic [srap_pkg::ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] ctrl;
    logic done;
    logic sclk;
    logic selN;
    logic serial_in;
    logic [31:0] prdata;
  } srap_host_t;

  srap_host_t cur;
  srap_host_t nxt;
  logic sdoS;

  // serial output comes from the far end, so it is synchronised
  srap_sync #(
    .WIDTH(1),
    .RESET_VAL(1'h1)
  ) sdoSyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(link.serialOut),
    .syncOut(sdoS)
  );

  ////////////////////////////////////////
  // bus, command and serial sequencer

  // zero wait bus: read data is registered in the setup cycle
  always_comb
  begin
    logic wr;
    logic halfDone;
    logic start;
    logic setDone;
    wr = psel & penable & pwrite;
    halfDone = cur.div == 16'(SCLK_HALF - 1);
    start = wr && paddr == srap_pkg::HOST_CTRL && pwdata[srap_pkg::CTRL_START];
    setDone = 1'b0;
    nxt = cur;
    nxt.div = halfDone ? 16'h0000 : cur.div + 16'h0001;
    if (psel && !penable)
    begin
      case (paddr)
        srap_pkg::HOST_CTRL: nxt.prdata = {28'h0000000, cur.ctrl};
        srap_pkg::HOST_ADDR: nxt.prdata = {17'h00000, cur.addr};
        srap_pkg::HOST_WDATA: nxt.prdata = {24'h000000, cur.wdata};
        srap_pkg::HOST_STATUS: nxt.prdata = {29'h00000000, cur.st == H_HOLD,
          cur.done, cur.st != H_IDLE && cur.st != H_HOLD};
        srap_pkg::HOST_RDATA: nxt.prdata = {24'h000000, cur.rdata};
        default: nxt.prdata = 32'h00000000;
      endcase
    end
    if (wr && paddr == srap_pkg::HOST_ADDR)
      nxt.addr = pwdata[srap_pkg::ADDR_W-1:0];
    if (wr && paddr == srap_pkg::HOST_WDATA)
      nxt.wdata = pwdata[7:0];
    if (wr && paddr == srap_pkg::HOST_CTRL)
      nxt.ctrl = pwdata[3:0];
    case (cur.st)
      H_IDLE:
        if (start)
        begin
          // new frame: direction, address, data, top bit first
          nxt.tx = {pwdata[srap_pkg::CTRL_READ], cur.addr, cur.wdata};
          nxt.left = 5'(srap_pkg::FRAME_BITS);
          nxt.selN = 1'b0;
          nxt.serial_in = pwdata[srap_pkg::CTRL_READ];
          nxt.div = 16'h0000;
          nxt.st = H_LOW;
        end
      H_LOW:
        if (halfDone)
        begin
          nxt.sclk = 1'b1;
          nxt.rx = {cur.rx[6:0], sdoS};
          nxt.st = H_HIGH;
        end
      H_HIGH:
        if (halfDone)
        begin
          nxt.sclk = 1'b0;
          nxt.left = cur.left - 5'h01;
          nxt.tx = {cur.tx[srap_pkg::FRAME_BITS-2:0], 1'b0};
          nxt.serial_in = cur.tx[srap_pkg::FRAME_BITS-2];
          if (cur.left == 5'h01)
          begin
            nxt.rdata = cur.rx;
            if (cur.ctrl[srap_pkg::CTRL_KEEP])
            begin
              setDone = 1'b1;
              nxt.st = H_HOLD;
            end
            else
              nxt.st = H_END;
          end
          else
            nxt.st = H_LOW;
        end
      H_HOLD:
        if (start)
        begin
          // stream one more byte under the same select
          nxt.tx = {cur.wdata, 16'h0000};
          nxt.serial_in = cur.wdata[7];
          nxt.left = 5'(srap_pkg::FRAME_BITS - srap_pkg::HEAD_BITS);
          nxt.div = 16'h0000;
          nxt.st = H_LOW;
        end
        else if (wr && paddr == srap_pkg::HOST_CTRL && pwdata[srap_pkg::CTRL_STOP])
        begin
          nxt.div = 16'h0000;
          nxt.st = H_END;
        end
      H_END:
        if (halfDone)
        begin
          nxt.selN = 1'b1;
          setDone = 1'b1;
          nxt.st = H_IDLE;
        end
      default: nxt.st = H_IDLE;
    endcase
    // sticky done: a new completion beats a clear in the same cycle
    nxt.done = (cur.done & ~(wr && paddr == srap_pkg::HOST_STATUS
      && pwdata[srap_pkg::ST_DONE])) | setDone;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      cur.st <= H_IDLE;
      cur.selN <= 1'b1;
    end
    else
      cur <= nxt;
  end

  ////////////////////////////////////////
  // outputs

  assign prdata = cur.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign link.sclk = cur.sclk;
  assign link.serialSelectN = cur.selN;
  assign link.serialIn = cur.serial_in;
endmodule

// ===== tb/srap_link_asserts.sv
// assertion checker watching the serial link between host and device ends
module srap_link_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link signals
  input wire logic sclk,
  input wire logic serialSelectN,
  input wire logic serialIn,
  input wire logic serialOutDrive,
  input wire logic serialOutEn,
  input wire logic serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclkD;
  logic isRead;
  logic [9:0] riseCnt;
  wire logic rise = sclk & ~sclkD;

  ////////////////////////////////////////
  // count serial clock rises of a frame straight from the pins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclkD <= 1'b0;
      riseCnt <= 10'h000;
      isRead <= 1'b0;
    end
    else
    begin
      sclkD <= sclk;
      if (serialSelectN)
        riseCnt <= 10'h000;
      else if (rise)
        riseCnt <= riseCnt + 10'h001;
      if (rise && riseCnt == 10'h000)
        isRead <= serialIn; // direction latched at the first rise
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // host side of the wire
  a_sclk_idle: assert property (serialSelectN |-> !sclk)
    else $error("serial clock high outside a frame");
  a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(serialIn))
    else $error("serial input moved while clock high");
  a_frame_len: assert property ($rose(serialSelectN) |->
    riseCnt >= 10'h018 && riseCnt[2:0] == 3'h0)
    else $error("frame not 24 clocks plus whole bytes");

  ////////////////////////////////////////
  // device output enable and data timing
  a_hdr_quiet: assert property (!serialSelectN && riseCnt < 10'h010 |-> !serialOutEn)
    else $error("output driven during header");
  a_write_quiet: assert property (!serialSelectN && riseCnt != 10'h000 && !isRead
    |-> !serialOutEn)
    else $error("output driven during write frame");
  a_read_drives: assert property (rise && isRead && riseCnt >= 10'h010 |-> serialOutEn)
    else $error("read data bit not driven");
  a_out_steady: assert property (sclk && $past(sclk) && serialOutEn
    |-> $stable(serialOutDrive))
    else $error("read data changed while clock high");
  a_release_off: assert property ($rose(serialSelectN) |-> ##[1:8] !serialOutEn)
    else $error("output still driven after select release");

  // main scenarios seen
  c_read: cover property ($rose(serialSelectN) && isRead);
  c_write: cover property ($rose(serialSelectN) && !isRead);
  c_stream: cover property ($rose(serialSelectN) && riseCnt > 10'h018);
endmodule

// ===== tb/test_serial_register_access_port.sv
// self-checking bench: apb commands make frames between the two ends
module test_serial_register_access_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
  logic clk;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic [7:0] calStatus;
  logic [7:0] syncPosition;
  logic [srap_pkg::NUM_SLOTS*8-1:0] fuseTrim;
  logic [srap_pkg::NUM_SLOTS*8-1:0] regImage;
  logic [23:0] sdiBits;
  logic [7:0] sdoBits;
  logic [31:0] q;
  int n_fail;
  int compares;
  int nRise;

  srap_link_if link ();
  srap_host_end #(.SCLK_HALF(8)) srap_host_end_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .link(link.host));
  srap_device_end #(.MAKER_ID(MAKER)) srap_device_end_i (.clk(clk), .reset_n(reset_n),
    .link(link.device), .fuseTrim(fuseTrim), .calStatus(calStatus),
    .syncPosition(syncPosition), .regImage(regImage));
  srap_link_asserts srap_link_asserts_i (.clk(clk), .reset_n(reset_n), .sclk(link.sclk),
    .serialSelectN(link.serialSelectN), .serialIn(link.serialIn),
    .serialOutDrive(link.serialOutDrive), .serialOutEn(link.serialOutEn),
    .serialOut(link.serialOut));

  ////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #1000000;
    n_fail++;
    end_sim();
  end

  // shadow of the wire, bits taken at each serial clock rise in a frame;
  // a select fall comes with the clock low, so it restarts the count
  always @(posedge link.sclk or negedge link.serialSelectN)
    if (!link.sclk)
      nRise <= 0;
    else if (!link.serialSelectN)
    begin
      sdiBits <= {sdiBits[22:0], link.serialIn};
      sdoBits <= {sdoBits[6:0], link.serialOut};
      nRise <= nRise + 1;
    end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // poll for the sticky done flag, then clear it
  task automatic waitDone();
    do
      apb(1'b0, srap_pkg::HOST_STATUS, 32'h0);
    while (q[srap_pkg::ST_DONE] !== 1'b1);
    apb(1'b1, srap_pkg::HOST_STATUS, 32'h2);
  endtask

  task automatic byteXfer(input logic [3:0] cmd, input logic [7:0] d);
    apb(1'b1, srap_pkg::HOST_WDATA, {24'h0, d});
    apb(1'b1, srap_pkg::HOST_CTRL, {28'h0, cmd});
    waitDone();
    apb(1'b0, srap_pkg::HOST_RDATA, 32'h0);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    apb(1'b1, srap_pkg::HOST_ADDR, {17'h0, a});
    byteXfer(4'h1, d);
  endtask

  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    apb(1'b1, srap_pkg::HOST_ADDR, {17'h0, a});
    byteXfer(4'h3, 8'h00);
    check(q, {24'h0, exp});
  endtask

  // streamed bytes held in the frame by keep, ended by stop
  task automatic stream(input logic r, input logic [14:0] a, input logic [7:0] b[$]);
    apb(1'b1, srap_pkg::HOST_ADDR, {17'h0, a});
    foreach (b[i])
    begin
      byteXfer({2'b01, r, 1'b1}, r ? 8'h00 : b[i]);
      if (r)
        check(q, {24'h0, b[i]});
    end
    apb(1'b1, srap_pkg::HOST_CTRL, 32'h8);
    waitDone();
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fuseTrim = {srap_pkg::NUM_SLOTS{8'hC3}};
    calStatus = 8'h5C;
    syncPosition = 8'h3E;
    n_fail = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(15'h000, 8'h30);
    rd(15'h010, 8'h00);
    rd(15'h030, 8'h00);
    rd(15'h031, 8'hA0);
    rd(15'h033, 8'hA0);
    rd(15'h07A, 8'hC3);
    rd(15'h152, 8'hC3);
    rd(15'h06A, 8'h5C);
    rd(15'h02C, 8'h3E);
    rd(15'h00C, MAKER[7:0]);
    rd(15'h00D, MAKER[15:8]);
    check({16'h0, sdiBits[23:8]}, {16'h0, 1'b1, 15'h00D});
    check({24'h0, sdoBits}, {24'h0, MAKER[15:8]});
    check(nRise, 24);
    wr(15'h060, 8'hA5);
    check({8'h0, sdiBits}, {8'h0, 1'b0, 15'h060, 8'hA5});
    rd(15'h060, 8'hA5);
    check({24'h0, regImage[18*8 +: 8]}, 32'hA5);
    wr(15'h06A, 8'h11);
    rd(15'h06A, 8'h5C);
    rd(15'h005, 8'h00);
    wr(15'h201, 8'h5A);
    rd(15'h201, 8'h5A);
    apb(1'b0, srap_pkg::HOST_ADDR, 32'h0);
    check(q, 32'h201);
    stream(1'b0, 15'h060, '{8'h11, 8'h22, 8'h33});
    check(nRise, 40);
    rd(15'h061, 8'h22);
    rd(15'h062, 8'h33);
    stream(1'b1, 15'h060, '{8'h11, 8'h22, 8'h33});
    wr(15'h000, 8'h00);
    stream(1'b0, 15'h062, '{8'h44, 8'h55});
    rd(15'h061, 8'h55);
    wr(15'h000, 8'h04);
    stream(1'b0, 15'h06B, '{8'h66, 8'h77});
    rd(15'h06C, 8'h77);
    wr(15'h010, 8'h01);
    stream(1'b0, 15'h070, '{8'h12, 8'h34});
    rd(15'h070, 8'h34);
    rd(15'h071, 8'h00);
    end_sim();
  end
endmodule
